// ==== boe_pkg.sv ====
// shared types and constants for the byte-op execute unit
package boe_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int PC_W    = 13;
    localparam int LIT_W   = 11;
    localparam int WDT_W   = 8;
    localparam int PRE_W   = 8;

    // ************************************************************
    // field positions and constants
    // ************************************************************
    localparam int LATCH_HI_POS = 4;
    localparam int LATCH_LO_POS = 3;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;
    localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;
    localparam logic [DATA_W-1:0] RST_ACCUM = 8'h00;
    localparam logic [PC_W-1:0]   RST_PC    = 13'h0000;
    localparam logic              DEST_ACC  = 1'b0;

    // ************************************************************
    // timing counts in instruction cycles
    // ************************************************************
    localparam logic [1:0] CYC_SINGLE = 2'h1;
    localparam logic [1:0] CYC_DOUBLE = 2'h2;

    // ************************************************************
    // operation codes from the decoder
    // ************************************************************
    typedef enum logic [2:0]
    {
        OP_NONE,
        OP_WATCHDOG_CLEAR,
        OP_CALL,
        OP_INVERT_REG,
        OP_REG_CLEAR,
        OP_REG_DECREMENT,
        OP_ACCUM_CLEAR,
        OP_DECREMENT_SKIP_NIL
    } boe_op_type;

    typedef struct packed
    {
        boe_op_type          op;
        logic [ADDR_W-1:0]   addr;
        logic                dest;
        logic [LIT_W-1:0]    lit;
    } boe_instr_type;

    typedef struct packed
    {
        logic                en;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } boe_reg_wr_type;

endpackage : boe_pkg

// ==== boe_alu.sv ====
// combinational result unit for the byte operations
`timescale 1ns/1ps
module boe_alu
    import boe_pkg::*;
(
    input  wire boe_op_type        i_op,
    input  wire logic [DATA_W-1:0] i_operand,
    output logic      [DATA_W-1:0] o_result,
    output logic                   o_zero
);

    always_comb
    begin
        case (i_op)
            OP_INVERT_REG:         o_result = ~i_operand;
            OP_REG_DECREMENT:      o_result = i_operand - ONE_BYTE;
            OP_DECREMENT_SKIP_NIL: o_result = i_operand - ONE_BYTE;
            default:               o_result = ZERO_BYTE;
        endcase
    end

    assign o_zero = (o_result == ZERO_BYTE);

endmodule : boe_alu

// ==== boe_exec.sv ====
// execute unit: clears, complement, decrements, watchdog clear and call
`timescale 1ns/1ps
module boe_exec
    import boe_pkg::*;
(
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_clk_en,
    input  wire logic                i_instr_valid,
    input  wire boe_instr_type       i_instr,
    input  wire logic [DATA_W-1:0]   i_file_rdata,
    input  wire logic [DATA_W-1:0]   i_upper_pc_latch,
    output logic                     o_ready,
    output logic [ADDR_W-1:0]        o_file_raddr,
    output boe_reg_wr_type           o_file_wr,
    output logic [DATA_W-1:0]        o_accum,
    output logic                     o_zero_flag,
    output logic                     o_expiry_flag,
    output logic                     o_sleep_entry_flag,
    output logic                     o_watchdog_clear,
    output logic [WDT_W-1:0]         o_watchdog_count_load,
    output logic [PRE_W-1:0]         o_prescaler_load,
    output logic                     o_stack_push,
    output logic [PC_W-1:0]          o_stack_head,
    output logic [PC_W-1:0]          o_pc,
    output logic                     o_flush,
    output logic [1:0]               o_cycles
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [0:0] {ST_IDLE, ST_SECOND} boe_state_type;

    boe_state_type     state;
    logic              take;
    logic              file_op;
    logic [DATA_W-1:0] alu_in;
    logic [DATA_W-1:0] alu_out;
    logic              alu_zero;
    logic              skip;
    logic              to_file;
    logic [PC_W-1:0]   next_pc;

    // the second cycle of a two-cycle instruction holds off the decoder
    assign o_ready = (state == ST_IDLE);
    assign take    = i_clk_en && i_instr_valid && o_ready;

    assign file_op = (i_instr.op == OP_INVERT_REG)
                  || (i_instr.op == OP_REG_DECREMENT)
                  || (i_instr.op == OP_DECREMENT_SKIP_NIL);

    // register file read port is combinational on the address
    assign o_file_raddr = i_instr.addr;
    // the previous write lands in the file only at this edge, so a
    // back-to-back access to the same register takes the pending byte
    assign alu_in = (o_file_wr.en && (o_file_wr.addr == i_instr.addr))
                  ? o_file_wr.data : i_file_rdata;

    boe_alu u_alu
    (
        .i_op      (i_instr.op),
        .i_operand (alu_in),
        .o_result  (alu_out),
        .o_zero    (alu_zero)
    );

    assign skip = (i_instr.op == OP_DECREMENT_SKIP_NIL) && alu_zero;
    assign to_file = (file_op && (i_instr.dest != DEST_ACC))
                  || (i_instr.op == OP_REG_CLEAR);

    // ************************************************************
    // sequencing
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state <= ST_IDLE;
        else if (i_clk_en)
        begin
            case (state)
                ST_IDLE:
                    if (take && ((i_instr.op == OP_CALL) || skip))
                        state <= ST_SECOND;
                ST_SECOND:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_cycles <= 2'h0;
        else if (i_clk_en && take)
            o_cycles <= ((i_instr.op == OP_CALL) || skip)
                      ? CYC_DOUBLE : CYC_SINGLE;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_flush <= 1'b0;
        else if (i_clk_en)
            o_flush <= take && skip;
    end

    // ************************************************************
    // data results
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_accum <= RST_ACCUM;
        else if (take && (i_instr.op == OP_ACCUM_CLEAR))
            o_accum <= ZERO_BYTE;
        else if (take && file_op && (i_instr.dest == DEST_ACC))
            o_accum <= alu_out;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_file_wr <= '0;
        else if (i_clk_en)
        begin
            o_file_wr.en   <= take && to_file;
            o_file_wr.addr <= i_instr.addr;
            o_file_wr.data <= alu_out;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_zero_flag <= 1'b0;
        else if (take)
        begin
            case (i_instr.op)
                OP_REG_CLEAR, OP_ACCUM_CLEAR:
                    o_zero_flag <= 1'b1;
                OP_INVERT_REG, OP_REG_DECREMENT:
                    o_zero_flag <= alu_zero;
                default:
                    o_zero_flag <= o_zero_flag;
            endcase
        end
    end

    // ************************************************************
    // watchdog clear
    // ************************************************************
    // flags reset low; only this block sets them, and only reset clears them
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_expiry_flag      <= 1'b0;
            o_sleep_entry_flag <= 1'b0;
        end
        else if (take && (i_instr.op == OP_WATCHDOG_CLEAR))
        begin
            o_expiry_flag      <= 1'b1;
            o_sleep_entry_flag <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_watchdog_clear <= 1'b0;
        else if (i_clk_en)
            o_watchdog_clear <= take
                && (i_instr.op == OP_WATCHDOG_CLEAR);
    end

    assign o_watchdog_count_load = ZERO_BYTE;
    assign o_prescaler_load      = ZERO_BYTE;

    // ************************************************************
    // program counter and call
    // ************************************************************
    always_comb
    begin
        next_pc = o_pc;
        if (take)
        begin
            if (i_instr.op == OP_CALL)
                next_pc = {i_upper_pc_latch[LATCH_HI_POS:LATCH_LO_POS],
                           i_instr.lit};
            else if (skip)
                next_pc = o_pc + PC_ONE + PC_ONE;
            else
                next_pc = o_pc + PC_ONE;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_pc <= RST_PC;
        else if (i_clk_en)
            o_pc <= next_pc;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_stack_push <= 1'b0;
            o_stack_head <= RST_PC;
        end
        else if (i_clk_en)
        begin
            o_stack_push <= take && (i_instr.op == OP_CALL);
            if (take && (i_instr.op == OP_CALL))
                o_stack_head <= o_pc + PC_ONE;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_WDT_CLEAR_PULSE:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_WATCHDOG_CLEAR |=> o_watchdog_clear)
    else $error("watchdog clear pulse missing");

    AST_WDT_FLAGS:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_WATCHDOG_CLEAR
        |=> o_expiry_flag && o_sleep_entry_flag && $stable(o_zero_flag))
    else $error("watchdog clear flags wrong");

    AST_CALL_PUSH:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_CALL
        |=> o_stack_push && o_stack_head == $past(o_pc) + PC_ONE)
    else $error("call return address wrong");

    AST_CALL_PC:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_CALL
        |=> o_pc[LIT_W-1:0] == $past(i_instr.lit))
    else $error("call low pc bits wrong");

    AST_CALL_UPPER:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_CALL
        |=> o_pc[PC_W-1:LIT_W]
            == $past(i_upper_pc_latch[LATCH_HI_POS:LATCH_LO_POS]))
    else $error("call upper pc bits wrong");

    AST_CALL_TWO:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_CALL && i_clk_en
        |=> !o_ready && $stable(o_zero_flag))
    else $error("call not two cycles");

    AST_DEST_ACC:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && file_op && i_instr.dest == DEST_ACC
        |=> !o_file_wr.en && o_accum == $past(alu_out))
    else $error("accumulator destination wrong");

    AST_INVERT:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_INVERT_REG && i_instr.dest
        |=> o_file_wr.en && o_file_wr.data == ~$past(alu_in))
    else $error("complement result wrong");

    AST_REG_CLEAR:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_REG_CLEAR
        |=> o_file_wr.en && o_file_wr.data == ZERO_BYTE && o_zero_flag)
    else $error("register clear wrong");

    AST_DECREMENT_ZERO:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_REG_DECREMENT
        |=> o_zero_flag == ($past(alu_in) == ONE_BYTE))
    else $error("decrement zero flag wrong");

    AST_SKIP:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        take && i_instr.op == OP_DECREMENT_SKIP_NIL
        |=> o_flush == ($past(alu_in) == ONE_BYTE)
            && $stable(o_zero_flag))
    else $error("decrement skip wrong");

endmodule : boe_exec

// ==== boe_regfile_model.sv ====
// behavioural data register file standing beside the execute unit
`timescale 1ns/1ps
module boe_regfile_model
    import boe_pkg::*;
(
    input  wire logic                i_core_clk,
    input  wire logic                i_clk_en,
    input  wire logic [ADDR_W-1:0]   i_raddr,
    input  wire boe_reg_wr_type      i_wr,
    output logic      [DATA_W-1:0]   o_rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // read is combinational, as the decoder presents the address early
    assign o_rdata = mem[i_raddr];

    always @(posedge i_core_clk)
    begin
        if (i_clk_en && i_wr.en)
        begin
            mem[i_wr.addr] <= i_wr.data;
        end
    end
endmodule : boe_regfile_model

// ==== tb_top.sv ====
// self-checking bench for the byte-op execute unit
`timescale 1ns/1ps
module tb_top;
    import boe_pkg::*;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                clk_en = 1'b1;
    logic                valid = 1'b0;
    boe_instr_type       instr = '0;
    logic [DATA_W-1:0]   latch = 8'h00;
    logic [DATA_W-1:0]   rdata;
    logic                ready, zero, expiry, sleep, wdc, push, flush;
    logic [ADDR_W-1:0]   raddr;
    boe_reg_wr_type      wr;
    logic [DATA_W-1:0]   accum, wdt_ld, pre_ld;
    logic [PC_W-1:0]     head, pc, exp_pc = 13'h0000;
    logic [1:0]          cycles;
    int                  err_total = 0;
    int                  n_compared = 0;
    int                  ticks = 0;

    always #2.5 clk = ~clk;

    boe_exec u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
        .i_instr_valid(valid), .i_instr(instr), .i_file_rdata(rdata),
        .i_upper_pc_latch(latch), .o_ready(ready), .o_file_raddr(raddr),
        .o_file_wr(wr), .o_accum(accum), .o_zero_flag(zero),
        .o_expiry_flag(expiry), .o_sleep_entry_flag(sleep),
        .o_watchdog_clear(wdc), .o_watchdog_count_load(wdt_ld),
        .o_prescaler_load(pre_ld), .o_stack_push(push),
        .o_stack_head(head), .o_pc(pc), .o_flush(flush), .o_cycles(cycles));

    boe_regfile_model u_regs (.i_core_clk(clk), .i_clk_en(clk_en),
        .i_raddr(raddr), .i_wr(wr), .o_rdata(rdata));

    task test_done;
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // ceiling well above the few dozen cycles the scenarios need
    always @(posedge clk)
    begin
        ticks++;
        if (ticks == 2000)
        begin
            err_total++;
            test_done();
        end
    end

    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : chk

    // offer one instruction, wait out a refusal, land after the taking edge;
    // valid stays up afterwards, and each offer drops it while refused and drives it high again
    task issue(input boe_op_type op, input logic [ADDR_W-1:0] a,
               input logic d, input logic [LIT_W-1:0] k,
               input logic [PC_W-1:0] npc);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 8)
        begin
            valid = 1'b0;
            @(posedge clk);
            #1;
            n++;
        end
        instr = '{op: op, addr: a, dest: d, lit: k};
        valid = 1'b1;
        @(posedge clk);
        #1;
        exp_pc = npc;
        chk("pc", {3'h0, exp_pc}, {3'h0, pc});
    endtask : issue

    task do_op(input boe_op_type op, input logic [ADDR_W-1:0] a,
               input logic d, input logic [7:0] fv, input logic [7:0] res);
        u_regs.mem[a] = fv;
        issue(op, a, d, 11'h000, exp_pc + 13'h0001);
        chk("wr_en", {15'h0, d}, {15'h0, wr.en});
        if (d)
        begin
            chk("wr_addr", {9'h0, a}, {9'h0, wr.addr});
            chk("wr_data", {8'h0, res}, {8'h0, wr.data});
        end
        else
            chk("accum", {8'h0, res}, {8'h0, accum});
        chk("zero", {15'h0, res == 8'h00}, {15'h0, zero});
        chk("cycles", 16'h1, {14'h0, cycles});
    endtask : do_op

    task t_decrement;
        do_op(OP_REG_DECREMENT, 7'h7f, 1'b1, 8'h05, 8'h04);
        issue(OP_REG_DECREMENT, 7'h7f, 1'b1, 11'h000,
              exp_pc + 13'h0001);
        chk("wr_data", 16'h3, {8'h0, wr.data});
        do_op(OP_REG_DECREMENT, 7'h00, 1'b0, 8'h01, 8'h00);
        do_op(OP_REG_DECREMENT, 7'h11, 1'b0, 8'h00, 8'hff);
    endtask : t_decrement

    task t_invert;
        do_op(OP_INVERT_REG, 7'h20, 1'b0, 8'hff, 8'h00);
        do_op(OP_INVERT_REG, 7'h21, 1'b1, 8'h5a, 8'ha5);
    endtask : t_invert

    task t_clears;
        do_op(OP_REG_CLEAR, 7'h30, 1'b1, 8'h9c, 8'h00);
        do_op(OP_REG_DECREMENT, 7'h31, 1'b0, 8'h05, 8'h04);
        u_regs.mem[7'h32] = 8'h77;
        issue(OP_ACCUM_CLEAR, 7'h32, 1'b0, 11'h000, exp_pc + 13'h0001);
        chk("accum", 16'h0, {8'h0, accum});
        chk("zero", 16'h1, {15'h0, zero});
        chk("wr_en", 16'h0, {15'h0, wr.en});
    endtask : t_clears

    task t_watchdog;
        chk("expiry", 16'h0, {15'h0, expiry});
        do_op(OP_REG_DECREMENT, 7'h40, 1'b0, 8'h03, 8'h02);
        issue(OP_WATCHDOG_CLEAR, 7'h00, 1'b0, 11'h000, exp_pc + 13'h0001);
        chk("wdt_clear", 16'h1, {15'h0, wdc});
        chk("wdt_load", 16'h0, {8'h0, wdt_ld});
        chk("pre_load", 16'h0, {8'h0, pre_ld});
        chk("expiry", 16'h1, {15'h0, expiry});
        chk("sleep", 16'h1, {15'h0, sleep});
        chk("zero", 16'h0, {15'h0, zero});
        chk("accum", 16'h2, {8'h0, accum});
        valid = 1'b0;
        @(posedge clk);
        #1;
        chk("wdt_clear", 16'h0, {15'h0, wdc});
    endtask : t_watchdog

    task t_call(input logic [7:0] l, input logic [LIT_W-1:0] k);
        logic [PC_W-1:0] ret;
        ret = exp_pc + 13'h0001;
        latch = l;
        issue(OP_CALL, 7'h00, 1'b0, k, {l[4:3], k});
        chk("push", 16'h1, {15'h0, push});
        chk("head", {3'h0, ret}, {3'h0, head});
        chk("cycles", 16'h2, {14'h0, cycles});
        chk("ready", 16'h0, {15'h0, ready});
        chk("zero", 16'h0, {15'h0, zero});
        // the call is still offered in its second cycle and must be refused
        @(posedge clk);
        #1;
        chk("pc_hold", {3'h0, exp_pc}, {3'h0, pc});
        chk("push", 16'h0, {15'h0, push});
        chk("ready", 16'h1, {15'h0, ready});
    endtask : t_call

    task t_skip;
        do_op(OP_REG_DECREMENT, 7'h50, 1'b0, 8'h05, 8'h04);
        u_regs.mem[7'h51] = 8'h01;
        issue(OP_DECREMENT_SKIP_NIL, 7'h51, 1'b1, 11'h000,
              exp_pc + 13'h0002);
        chk("wr_data", 16'h0, {8'h0, wr.data});
        chk("flush", 16'h1, {15'h0, flush});
        chk("cycles", 16'h2, {14'h0, cycles});
        chk("zero", 16'h0, {15'h0, zero});
        chk("ready", 16'h0, {15'h0, ready});
        u_regs.mem[7'h52] = 8'h02;
        issue(OP_DECREMENT_SKIP_NIL, 7'h52, 1'b0, 11'h000,
              exp_pc + 13'h0001);
        chk("accum", 16'h1, {8'h0, accum});
        chk("flush", 16'h0, {15'h0, flush});
        chk("cycles", 16'h1, {14'h0, cycles});
    endtask : t_skip

    // an instruction offered while the enable is low must wait for it
    task t_freeze;
        u_regs.mem[7'h70] = 8'h01;
        clk_en = 1'b0;
        issue(OP_REG_DECREMENT, 7'h70, 1'b1, 11'h000, exp_pc);
        chk("wr_en", 16'h0, {15'h0, wr.en});
        chk("accum", 16'h1, {8'h0, accum});
        clk_en = 1'b1;
        @(posedge clk);
        #1;
        exp_pc = exp_pc + 13'h0001;
        chk("pc", {3'h0, exp_pc}, {3'h0, pc});
        chk("wr_en", 16'h1, {15'h0, wr.en});
        chk("wr_data", 16'h0, {8'h0, wr.data});
        chk("zero", 16'h1, {15'h0, zero});
        valid = 1'b0;
    endtask : t_freeze

    // reset in mid-run clears state and work resumes at pc zero
    task t_reset;
        valid = 1'b0;
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        chk("pc", 16'h0, {3'h0, pc});
        chk("accum", 16'h0, {8'h0, accum});
        chk("expiry", 16'h0, {15'h0, expiry});
        chk("sleep", 16'h0, {15'h0, sleep});
        chk("ready", 16'h1, {15'h0, ready});
        rst_n = 1'b1;
        exp_pc = 13'h0000;
        do_op(OP_REG_DECREMENT, 7'h71, 1'b0, 8'h80, 8'h7f);
    endtask : t_reset

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_decrement();
        t_invert();
        t_clears();
        t_watchdog();
        do_op(OP_REG_DECREMENT, 7'h60, 1'b0, 8'h09, 8'h08);
        t_call(8'h18, 11'h7ff);
        t_call(8'he7, 11'h400);
        t_skip();
        t_freeze();
        t_reset();
        @(posedge clk);
        test_done();
    end
endmodule : tb_top
